// file: hdl/tcx_timer.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tcx_timer #(
    parameter bit FULL_VARIANT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] evt_in,
    input wire logic [3:0] cap_pin,
    input wire logic [7:0] port_val,
    output logic [7:0] pin_out,
    output logic ovf_evt,
    output logic hunf_evt,
    output logic err_evt,
    output logic [3:0] cc_evt,
    output logic [1:0] res_ext_mode
);
    localparam int NCH = FULL_VARIANT ? 4 : 2;
    localparam logic [3:0] CH_MASK = FULL_VARIANT ? 4'hF : 4'h3;

    tcx_pkg::tcx_ctrl_t ctrl_reg;
    logic [7:0] stat_reg, pin_out_reg, wg_reg, wg_next, pin_next;
    logic [31:0] rdata;
    logic [15:0] cnt_reg, cnt_next, per_buf_reg, per_act_reg, top, dti_buf_reg, dti_act_reg, pat_reg;
    logic [7:0] pat_act_reg;
    logic [3:0][15:0] cc_buf_reg, cc_act_reg;
    logic [5:0] psc_reg;
    logic up_reg, up_next, ovf_hit, hunf_hit, tick_raw, tick, upd, dir_dn, split_on, ext_on;
    logic wr, cnt_wr, restart, fault_hit, fault_now, dti_busy, err_set;
    logic [3:0] cs1_reg, cs2_reg, cs3_reg, lvl_reg, flt_reg, fltd_reg, rise, fall, cap_go, ccm, ls_o, hs_o, busy;
    logic [3:0][3:0] hist_reg;
    logic [31:0] prdata_reg;

    function automatic logic tcx_hit(input logic [7:0] a);
        tcx_hit = (a == tcx_pkg::ADDR_CTRL) || (a == tcx_pkg::ADDR_STAT) || (a == tcx_pkg::ADDR_CNT)
            || (a == tcx_pkg::ADDR_PER) || (a == tcx_pkg::ADDR_DTI) || (a == tcx_pkg::ADDR_PAT)
            || (a >= tcx_pkg::ADDR_CC0 && a < tcx_pkg::ADDR_CC0 + 8'(4 * NCH) && a[1:0] == 2'b00);
    endfunction

    function automatic logic tcx_cc_sel(input logic [7:0] a, input int i);
        tcx_cc_sel = (a == tcx_pkg::ADDR_CC0 + 8'(4 * i)) && (i < NCH);
    endfunction

    // Zero wait states; read data is captured in the setup phase so it comes from a flop
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~tcx_hit(paddr);
    assign prdata = prdata_reg;
    assign wr = psel & penable & pwrite & tcx_hit(paddr);
    assign cnt_wr = wr && paddr == tcx_pkg::ADDR_CNT;

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (paddr)
            tcx_pkg::ADDR_CTRL: rdata = ctrl_reg;
            tcx_pkg::ADDR_STAT: rdata = {24'h00_0000, stat_reg};
            tcx_pkg::ADDR_CNT: rdata = {16'h0000, cnt_reg};
            tcx_pkg::ADDR_PER: rdata = {16'h0000, per_buf_reg};
            tcx_pkg::ADDR_DTI: rdata = {16'h0000, dti_buf_reg};
            tcx_pkg::ADDR_PAT: rdata = {16'h0000, pat_reg};
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (tcx_cc_sel(paddr, i)) begin
                        rdata = {16'h0000, cc_buf_reg[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= tcx_pkg::CTRL_RST;
            per_buf_reg <= tcx_pkg::PER_RST;
            dti_buf_reg <= tcx_pkg::DTI_RST;
            pat_reg <= 16'h0000;
        end else if (wr) begin
            if (paddr == tcx_pkg::ADDR_CTRL) ctrl_reg <= pwdata;
            if (paddr == tcx_pkg::ADDR_PER) per_buf_reg <= pwdata[15:0];
            if (paddr == tcx_pkg::ADDR_DTI) dti_buf_reg <= pwdata[15:0];
            if (paddr == tcx_pkg::ADDR_PAT) pat_reg <= pwdata[15:0];
        end
    end

    assign split_on = FULL_VARIANT & ctrl_reg.split;
    assign ext_on = FULL_VARIANT & ctrl_reg.ext_en;
    assign dir_dn = ctrl_reg.dir_down ^ (ctrl_reg.evdir_en & evt_in[tcx_pkg::EV_DIR]);
    assign top = (ctrl_reg.wg == tcx_pkg::WG_FREQ) ? cc_act_reg[0] : per_act_reg;

    // Prescaler runs free so a clock source change takes effect within one divided period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_reg <= 6'h00;
        end else begin
            psc_reg <= psc_reg + 6'h01;
        end
    end

    always_comb begin
        unique case (ctrl_reg.clk_sel)
            tcx_pkg::CLK_OFF: tick_raw = 1'b0;
            tcx_pkg::CLK_DIV1: tick_raw = 1'b1;
            tcx_pkg::CLK_DIV2: tick_raw = psc_reg[0];
            tcx_pkg::CLK_DIV8: tick_raw = &psc_reg[2:0];
            tcx_pkg::CLK_DIV64: tick_raw = &psc_reg;
            tcx_pkg::CLK_EVT: tick_raw = evt_in[tcx_pkg::EV_CLK];
            default: tick_raw = 1'b0;
        endcase
    end

    // Both split halves see this one tick
    assign tick = tick_raw & ~(ctrl_reg.dti_halt & dti_busy);

    always_comb begin
        cnt_next = cnt_reg;
        up_next = up_reg;
        ovf_hit = 1'b0;
        hunf_hit = 1'b0;
        if (split_on) begin
            if (cnt_reg[7:0] == 8'h00) begin
                cnt_next[7:0] = per_act_reg[7:0];
                ovf_hit = 1'b1;
            end else begin
                cnt_next[7:0] = cnt_reg[7:0] - 8'h01;
            end
            if (cnt_reg[15:8] == 8'h00) begin
                cnt_next[15:8] = per_act_reg[15:8];
                hunf_hit = 1'b1;
            end else begin
                cnt_next[15:8] = cnt_reg[15:8] - 8'h01;
            end
        end else if (ctrl_reg.wg == tcx_pkg::WG_DS) begin
            if (up_reg) begin
                if (cnt_reg >= top) begin
                    up_next = 1'b0;
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end else if (cnt_reg == 16'h0000) begin
                up_next = 1'b1;
                cnt_next = 16'h0001;
                ovf_hit = 1'b1;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end else if (dir_dn) begin
            if (cnt_reg == 16'h0000) begin
                cnt_next = top;
                ovf_hit = 1'b1;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end else if (cnt_reg >= top) begin
            cnt_next = 16'h0000;
            ovf_hit = 1'b1;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    assign upd = tick & ovf_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
            up_reg <= 1'b1;
        end else if (cnt_wr) begin
            cnt_reg <= pwdata[15:0];
        end else if (restart) begin
            cnt_reg <= 16'h0000;
            up_reg <= 1'b1;
        end else if (tick) begin
            cnt_reg <= cnt_next;
            up_reg <= up_next;
        end
    end

    // Active copies change only at the end of a count cycle to avoid runt pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_act_reg <= tcx_pkg::PER_RST;
            cc_act_reg <= {4{tcx_pkg::CC_RST}};
            dti_act_reg <= tcx_pkg::DTI_RST;
            pat_act_reg <= 8'h00;
        end else if (upd) begin
            per_act_reg <= per_buf_reg;
            cc_act_reg <= cc_buf_reg;
            dti_act_reg <= dti_buf_reg;
            pat_act_reg <= pat_reg[15:8];
        end
    end

    // Pin inputs: three flops, a level counts once the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs1_reg <= 4'h0;
            cs2_reg <= 4'h0;
            cs3_reg <= 4'h0;
            lvl_reg <= 4'h0;
        end else begin
            cs1_reg <= cap_pin;
            cs2_reg <= cs1_reg;
            cs3_reg <= cs2_reg;
            lvl_reg <= (cs2_reg & cs3_reg) | (lvl_reg & (cs2_reg | cs3_reg));
        end
    end

    generate
        for (genvar i = 0; i < 4; i++) begin : g_ch
            // Noise canceller needs four equal samples; costs four cycles of latency
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hist_reg[i] <= 4'h0;
                    flt_reg[i] <= 1'b0;
                    fltd_reg[i] <= 1'b0;
                end else begin
                    hist_reg[i] <= {hist_reg[i][2:0], lvl_reg[i]};
                    fltd_reg[i] <= flt_reg[i];
                    if (!ctrl_reg.nc_en) begin
                        flt_reg[i] <= lvl_reg[i];
                    end else if (&hist_reg[i]) begin
                        flt_reg[i] <= 1'b1;
                    end else if (~|hist_reg[i]) begin
                        flt_reg[i] <= 1'b0;
                    end
                end
            end
            assign rise[i] = flt_reg[i] & ~fltd_reg[i];
            assign fall[i] = ~flt_reg[i] & fltd_reg[i];
            always_comb begin
                cap_go[i] = 1'b0;
                if (ctrl_reg.capture && CH_MASK[i]) begin
                    unique case (ctrl_reg.cap_kind)
                        tcx_pkg::CAP_INPUT: cap_go[i] = rise[i] | evt_in[tcx_pkg::EV_CAP];
                        tcx_pkg::CAP_FREQ: cap_go[i] = rise[i];
                        tcx_pkg::CAP_PW: cap_go[i] = fall[i];
                        default: cap_go[i] = 1'b0;
                    endcase
                end
            end
            assign ccm[i] = ~ctrl_reg.capture & CH_MASK[i] & tick
                & (split_on ? cnt_reg[7:0] == cc_act_reg[i][7:0] : cnt_reg == cc_act_reg[i]);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cc_buf_reg[i] <= tcx_pkg::CC_RST;
                end else if (cap_go[i]) begin
                    cc_buf_reg[i] <= cnt_reg;
                end else if (wr && tcx_cc_sel(paddr, i)) begin
                    cc_buf_reg[i] <= pwdata[15:0];
                end
            end
        end
    endgenerate

    assign restart = ctrl_reg.capture && |(rise & CH_MASK)
        && (ctrl_reg.cap_kind == tcx_pkg::CAP_FREQ || ctrl_reg.cap_kind == tcx_pkg::CAP_PW);
    assign err_set = |(cap_go & stat_reg[tcx_pkg::ST_CC0 +: 4]);
    assign fault_hit = |(evt_in & ctrl_reg.fault_mask);
    assign fault_now = stat_reg[tcx_pkg::ST_FAULT] | fault_hit;

    // Status flags: write one to clear, a same-cycle set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= 8'h00;
        end else begin
            stat_reg <= (stat_reg & ~((wr && paddr == tcx_pkg::ADDR_STAT) ? pwdata[7:0] : 8'h00))
                | {fault_hit, hunf_hit & tick, ccm | cap_go, err_set, upd};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_evt <= 1'b0;
            hunf_evt <= 1'b0;
            err_evt <= 1'b0;
            cc_evt <= 4'h0;
        end else begin
            ovf_evt <= upd;
            hunf_evt <= hunf_hit & tick;
            err_evt <= err_set;
            cc_evt <= ccm | cap_go;
        end
    end

    always_comb begin
        wg_next = 8'h00;
        if (!ctrl_reg.capture) begin
            for (int i = 0; i < NCH; i++) begin
                if (split_on) begin
                    wg_next[i] = cnt_reg[7:0] < cc_act_reg[i][7:0];
                    wg_next[i + 4] = cnt_reg[15:8] < cc_act_reg[i][15:8];
                end else if (ctrl_reg.wg == tcx_pkg::WG_SS || ctrl_reg.wg == tcx_pkg::WG_DS) begin
                    wg_next[i] = cnt_reg < cc_act_reg[i];
                end
            end
            if (!split_on && ctrl_reg.wg == tcx_pkg::WG_FREQ) begin
                wg_next[0] = wg_reg[0] ^ upd;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wg_reg <= 8'h00;
        end else begin
            wg_reg <= wg_next;
        end
    end

    generate
        for (genvar i = 0; i < 4; i++) begin : g_dti
            logic prev_reg;
            logic [7:0] ls_cnt_reg, hs_cnt_reg;
            // Separate counters so each side's gap is timed on its own
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prev_reg <= 1'b0;
                    ls_cnt_reg <= 8'h00;
                    hs_cnt_reg <= 8'h00;
                end else begin
                    prev_reg <= wg_reg[i];
                    if (wg_reg[i] && !prev_reg) begin
                        ls_cnt_reg <= dti_act_reg[7:0];
                    end else if (tick_raw && ls_cnt_reg != 8'h00) begin
                        ls_cnt_reg <= ls_cnt_reg - 8'h01;
                    end
                    if (!wg_reg[i] && prev_reg) begin
                        hs_cnt_reg <= dti_act_reg[15:8];
                    end else if (tick_raw && hs_cnt_reg != 8'h00) begin
                        hs_cnt_reg <= hs_cnt_reg - 8'h01;
                    end
                end
            end
            // One pclk of gap even at zero dead time, so sides never overlap
            assign ls_o[i] = wg_reg[i] & prev_reg & (ls_cnt_reg == 8'h00);
            assign hs_o[i] = ~wg_reg[i] & ~prev_reg & (hs_cnt_reg == 8'h00);
            assign busy[i] = (ls_cnt_reg != 8'h00) | (hs_cnt_reg != 8'h00);
        end
    endgenerate

    assign dti_busy = ext_on & |busy;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_next[i] = pat_reg[i] ? wg_reg[i] : port_val[i];
            if (ext_on) begin
                if (fault_now) begin
                    pin_next[i] = pat_reg[i] ? 1'b0 : port_val[i];
                end else if (ctrl_reg.pat_en) begin
                    pin_next[i] = pat_reg[i] ? pat_act_reg[i] : port_val[i];
                end else if (ctrl_reg.dist_a) begin
                    pin_next[i] = i[0] ? hs_o[0] : ls_o[0];
                end else if (pat_reg[i]) begin
                    pin_next[i] = i[0] ? hs_o[i / 2] : ls_o[i / 2];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_reg <= 8'h00;
        end else begin
            pin_out_reg <= pin_next;
        end
    end

    assign pin_out = pin_out_reg;
    // The fast-clock stage outside reads this mode; 2'b10 is four times, 2'b11 eight
    assign res_ext_mode = ctrl_reg.res_ext;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_reduced_cc;
        !FULL_VARIANT |-> cc_evt[3:2] == 2'b00 && wg_reg[3:2] == 2'b00;
    endproperty
    a_reduced_cc: assert property (p_reduced_cc) else $error("reduced variant channel active");

    property p_capture_no_wg;
        ctrl_reg.capture |=> wg_reg == 8'h00;
    endproperty
    a_capture_no_wg: assert property (p_capture_no_wg) else $error("waveform in capture mode");

    property p_split_only_full;
        !FULL_VARIANT |-> wg_reg[7:4] == 4'h0 && !hunf_evt;
    endproperty
    a_split_only_full: assert property (p_split_only_full) else $error("split on reduced variant");

    property p_split_down;
        split_on && tick && cnt_reg[7:0] != 8'h00 && !cnt_wr && !restart
            |=> cnt_reg[7:0] == $past(cnt_reg[7:0]) - 8'h01;
    endproperty
    a_split_down: assert property (p_split_down) else $error("split low byte not counting down");

    property p_per_buffered;
        !$stable(per_act_reg) |-> $past(upd);
    endproperty
    a_per_buffered: assert property (p_per_buffered) else $error("period changed mid cycle");

    property p_ovf_flag;
        upd |=> ovf_evt && stat_reg[tcx_pkg::ST_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged");

    property p_no_overlap;
        (ls_o & hs_o) == 4'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("low and high side overlap");

    property p_halt;
        ctrl_reg.dti_halt && dti_busy && !cnt_wr && !restart |=> $stable(cnt_reg);
    endproperty
    a_halt: assert property (p_halt) else $error("counter ran during dead time");

    property p_pattern;
        ext_on && ctrl_reg.pat_en && !fault_now
            |=> pin_out == (($past(pat_act_reg) & $past(pat_reg[7:0])) | ($past(port_val) & ~$past(pat_reg[7:0])));
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern not on pins");

    property p_fault_kill;
        ext_on && fault_hit |=> (pin_out & $past(pat_reg[7:0])) == 8'h00 && stat_reg[tcx_pkg::ST_FAULT];
    endproperty
    a_fault_kill: assert property (p_fault_kill) else $error("fault did not disable outputs");

    c_fault: cover property (ext_on && fault_hit);
    c_split_unf: cover property (split_on && upd);
    c_capture: cover property (|cap_go);
    c_dti_busy: cover property (dti_busy ##1 !dti_busy);
endmodule

// file: hdl/tcx_pkg.sv
package tcx_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CNT = 8'h08;
    localparam logic [7:0] ADDR_PER = 8'h0C;
    localparam logic [7:0] ADDR_CC0 = 8'h10;
    localparam logic [7:0] ADDR_DTI = 8'h20;
    localparam logic [7:0] ADDR_PAT = 8'h24;
    localparam logic [15:0] PER_RST = 16'hFFFF;
    localparam logic [15:0] CC_RST = 16'h0000;
    localparam logic [15:0] DTI_RST = 16'h0000;
    localparam int NUM_EVT = 4;
    localparam int EV_CLK = 0;
    localparam int EV_DIR = 1;
    localparam int EV_CAP = 2;
    localparam int ST_OVF = 0;
    localparam int ST_ERR = 1;
    localparam int ST_CC0 = 2;
    localparam int ST_HUNF = 6;
    localparam int ST_FAULT = 7;
    typedef enum logic [2:0] {
        CLK_OFF = 3'b000, CLK_DIV1 = 3'b001, CLK_DIV2 = 3'b010,
        CLK_DIV8 = 3'b011, CLK_DIV64 = 3'b100, CLK_EVT = 3'b101
    } tcx_clk_t;
    typedef enum logic [1:0] {WG_NORMAL = 2'b00, WG_FREQ = 2'b01, WG_SS = 2'b10, WG_DS = 2'b11} tcx_wg_t;
    typedef enum logic [1:0] {CAP_INPUT = 2'b00, CAP_FREQ = 2'b01, CAP_PW = 2'b10, CAP_RSV = 2'b11} tcx_cap_t;
    typedef struct packed {
        logic [9:0] rsv;
        logic [1:0] res_ext;
        logic nc_en;
        logic [3:0] fault_mask;
        tcx_cap_t cap_kind;
        logic dti_halt;
        logic dist_a;
        logic pat_en;
        logic ext_en;
        logic evdir_en;
        logic dir_down;
        logic split;
        logic capture;
        tcx_wg_t wg;
        tcx_clk_t clk_sel;
    } tcx_ctrl_t;
    localparam tcx_ctrl_t CTRL_RST = '0;
endpackage

// file: verif/tcx_power_stage.sv
`timescale 1ns/1ps
module tcx_power_stage (
    input wire logic pclk,
    input wire logic armed,
    input wire logic [7:0] pin_out,
    input wire logic [3:0] cap_req,
    output logic [3:0] cap_pin,
    output int overlaps,
    output int ls_rises
);
    logic ls_q;
    // Sensor lines change freely, unrelated to pclk
    assign cap_pin = cap_req;
    initial begin
        overlaps = 0;
        ls_rises = 0;
        ls_q = 1'b0;
    end
    always @(posedge pclk) begin
        ls_q <= pin_out[0];
        if (armed && pin_out[0] === 1'b1 && !ls_q) ls_rises <= ls_rises + 1;
        // Both switches of one leg on at once would short the supply
        for (int k = 0; k < 4; k++) begin
            if (armed && pin_out[2*k] === 1'b1 && pin_out[2*k+1] === 1'b1) begin
                overlaps <= overlaps + 1;
            end
        end
    end
endmodule

// file: verif/tcx_timer_tb.sv
`timescale 1ns/1ps
module tcx_timer_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ovf_evt, hunf_evt, err_evt, armed, er;
    logic [7:0] paddr, port_val, pin_out;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] evt_in, cap_pin, cap_req, cc_evt;
    logic [1:0] res_ext_mode;
    logic [6:0] evts;
    int failures, n_tests, overlaps, ls_rises;
    assign evts = {cc_evt, err_evt, hunf_evt, ovf_evt};
    tcx_timer tcx_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_in(evt_in),
        .cap_pin(cap_pin), .port_val(port_val), .pin_out(pin_out), .ovf_evt(ovf_evt), .hunf_evt(hunf_evt),
        .err_evt(err_evt), .cc_evt(cc_evt), .res_ext_mode(res_ext_mode));
    tcx_power_stage tcx_power_stage_inst (.pclk(pclk), .armed(armed), .pin_out(pin_out), .cap_req(cap_req),
        .cap_pin(cap_pin), .overlaps(overlaps), .ls_rises(ls_rises));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic summarize();
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
            summarize();
        end
    endtask
    task automatic wait_evt(input int b, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (evts[b] !== 1'b1 && n < lim);
        check({31'h0, evts[b]}, 32'h1);
        if (n >= lim) summarize();
    endtask
    // Counter preset to the top so the first tick loads the short period
    task automatic run(input logic [31:0] per, input logic [31:0] ctrl);
        apb(1'b1, tcx_pkg::ADDR_PER, per);
        apb(1'b1, tcx_pkg::ADDR_CNT, 32'h0000FFFF);
        apb(1'b1, tcx_pkg::ADDR_CTRL, ctrl);
    endtask
    task automatic t_reset();
        apb(1'b0, tcx_pkg::ADDR_PER, 32'h0);
        check(rd, {16'h0, tcx_pkg::PER_RST});
        apb(1'b1, 8'h3C, 32'hFFFFFFFF);
        check({31'h0, er}, 32'h1);
        apb(1'b0, 8'h3C, 32'h0);
        check(rd, 32'h0);
        check(pin_out, port_val);
        apb(1'b1, tcx_pkg::ADDR_CTRL, 32'h0030_0000);
        #1;
        check(res_ext_mode, 32'h3);
    endtask
    task automatic t_evclock();
        apb(1'b1, tcx_pkg::ADDR_CNT, 32'h0);
        apb(1'b1, tcx_pkg::ADDR_CTRL, 32'h5);
        repeat (3) begin
            @(posedge pclk);
            evt_in <= 4'h1;
            @(posedge pclk);
            evt_in <= 4'h0;
        end
        apb(1'b0, tcx_pkg::ADDR_CNT, 32'h0);
        check(rd, 32'h3);
    endtask
    task automatic t_compare();
        apb(1'b1, tcx_pkg::ADDR_CC0, 32'h5);
        run(32'hF, 32'h11);
        wait_evt(3, 100);
        wait_evt(0, 100);
        apb(1'b0, tcx_pkg::ADDR_STAT, 32'h0);
        check(rd & 32'h5, 32'h5);
    endtask
    task automatic t_dead();
        apb(1'b1, tcx_pkg::ADDR_DTI, 32'h0303);
        apb(1'b1, tcx_pkg::ADDR_PAT, 32'h00FF);
        apb(1'b1, tcx_pkg::ADDR_CC0, 32'h8);
        armed <= 1'b1;
        // Halt on, so the counter freezes while a gap is timed
        run(32'hF, 32'h1211);
        repeat (200) @(posedge pclk);
        armed <= 1'b0;
        #1;
        check(overlaps, 0);
        check(ls_rises > 5, 1);
    endtask
    task automatic t_pattern_fault();
        apb(1'b1, tcx_pkg::ADDR_PAT, 32'hA5FF);
        run(32'hF, 32'h40611);
        repeat (40) @(posedge pclk);
        #1;
        check(pin_out, 8'hA5);
        @(posedge pclk);
        evt_in <= 4'h8;
        @(posedge pclk);
        evt_in <= 4'h0;
        #1;
        check(pin_out, 8'h00);
        apb(1'b0, tcx_pkg::ADDR_STAT, 32'h0);
        check(rd & 32'h80, 32'h80);
    endtask
    task automatic t_split_capture();
        run(32'h0404, 32'h41);
        wait_evt(1, 100);
        run(32'hF, 32'h21);
        @(posedge pclk);
        cap_req <= 4'h1;
        wait_evt(3, 50);
        // Channel 0 flag is still set from the compare runs, so this capture overruns
        check({31'h0, err_evt}, 32'h1);
    endtask
    initial begin
        {psel, penable, pwrite, armed, er} = '0;
        {paddr, pwdata, evt_in, cap_req, failures, n_tests} = '0;
        port_val = 8'h3C;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_evclock();
        t_compare();
        t_dead();
        t_pattern_fault();
        t_split_capture();
        summarize();
    end
endmodule
